/* rtl/asq_ctrl.sv */
// Purpose: Converter sequencer, control register and indirect addressing.
// Assumes: Triggers, SAR data and power modes come from same-clock logic.
// Notes: External interrupt pin is synchronised; Avalon answer in 1 cycle.
`timescale 1ns/100ps
`include "asq_params.svh"
module asq_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_idle_mode,
    input wire logic i_sleep_mode,
    input wire logic i_ext_int_pin,
    input wire logic i_timer3_trig,
    input wire logic i_timer1_trig,
    input wire logic i_charge_time_unit_trig,
    input wire logic [4:0] i_channel,
    input wire logic [11:0] i_sar_data,
    output logic o_sampling,
    output logic o_converting,
    output logic o_done,
    output logic [15:0] o_result,
    output logic o_result_valid,
    output logic [10:0] o_indirect_offset,
    output logic [15:0] o_dma_address
);

    asq_pkg::asq_regs_t r_ff;
    asq_pkg::asq_regs_t nxt_r;
    logic tick;
    logic trig;
    logic per_channel_indirect_mode;
    logic halted;
    logic int_edge;
    logic [4:0] conv_len;
    logic [10:0] pia_now;
    logic [31:0] ctrl_rd;
    logic [31:0] cfg_rd;
    logic [31:0] wv;
    logic [4:0] hlp_ticks_ff;

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        wmerge = (old & ~m) | (wd & m);
    endfunction : wmerge

    function automatic logic [10:0] pia_off(input logic [4:0] ch,
                                            input logic [6:0] ix,
                                            input logic [2:0] sz);
        logic [17:0] t;
        logic [6:0] m;
        m = 7'((8'h01 << sz) - 8'h01);
        // Upper channel bits fall off above 11 bits: 16 or 8 channels at size codes 6 and 7
        t = (18'(ch) << ({1'b0, sz} + 4'h1)) | (18'(ix & m) << 1); // [RULE_01] [RULE_02]
        pia_off = t[10:0];
    endfunction : pia_off

    function automatic logic [15:0] fmt_res(input logic [11:0] raw,
                                            input logic m12,
                                            input logic [1:0] f);
        logic [15:0] u;
        logic [15:0] s;
        logic [15:0] l;
        u = m12 ? {4'h0, raw} : {6'h00, raw[9:0]};
        s = m12 ? {{5{~raw[11]}}, raw[10:0]} : {{7{~raw[9]}}, raw[8:0]};
        l = m12 ? {raw, 4'h0} : {raw[9:0], 6'h00};
        case (f) // [RULE_13]
            2'h0: fmt_res = u;
            2'h1: fmt_res = s;
            2'h2: fmt_res = l;
            default: fmt_res = l ^ 16'h8000;
        endcase
    endfunction : fmt_res

    // Bits 14 and 3 are not stored, so they always read zero
    assign ctrl_rd = {16'h0000, r_ff.on, 1'b0, r_ff.idle_stop, r_ff.buf_mode,
                      r_ff.ext_en, r_ff.res12, r_ff.fmt, r_ff.trig_src, 1'b0,
                      r_ff.auto_sample_start, r_ff.sample_flag, r_ff.done}; // [RULE_18]
    assign cfg_rd = {3'h0, r_ff.sample_flag_time, 5'h00, r_ff.sub_size, 3'h0,
                     r_ff.inc_rate, r_ff.div};
    assign tick = (r_ff.pre == r_ff.div); // [RULE_06]
    assign halted = r_ff.idle_stop & i_idle_mode; // [RULE_09]
    assign per_channel_indirect_mode = r_ff.ext_en & ~r_ff.buf_mode; // [RULE_10] [RULE_11]
    assign conv_len = r_ff.res12 ? `ASQ_CONV_TAD_12 : `ASQ_CONV_TAD_10; // [RULE_12]
    assign pia_now = pia_off(r_ff.chan, r_ff.idx, r_ff.sub_size);
    assign int_edge = r_ff.int_s2 & ~r_ff.int_d;

    always_comb begin
        case (r_ff.trig_src) // [RULE_14] [RULE_23]
            `ASQ_TRIG_INT: trig = int_edge;
            `ASQ_TRIG_TMR3: trig = i_timer3_trig;
            `ASQ_TRIG_CTU: trig = i_charge_time_unit_trig;
            `ASQ_TRIG_T1NS: trig = i_timer1_trig & ~i_sleep_mode; // [RULE_15]
            `ASQ_TRIG_T1: trig = i_timer1_trig; // [RULE_15]
            `ASQ_TRIG_AUTO: trig = (r_ff.tcnt == r_ff.sample_flag_time);
            default: trig = 1'b0;
        endcase
    end

    always_comb begin
        nxt_r = r_ff;
        wv = 32'h0000_0000;
        nxt_r.int_s1 = i_ext_int_pin;
        nxt_r.int_s2 = r_ff.int_s1;
        nxt_r.int_d = r_ff.int_s2;
        nxt_r.rvalid = 1'b0;
        // Bus: request seen while waiting, answered the next cycle
        nxt_r.waitreq = ~((i_avs_read | i_avs_write) & r_ff.waitreq);
        if ((i_avs_read | i_avs_write) & r_ff.waitreq) begin
            case (i_avs_address)
                `ASQ_OFF_CTRL: nxt_r.rdata = ctrl_rd;
                `ASQ_OFF_CFG: nxt_r.rdata = cfg_rd;
                `ASQ_OFF_BASE: nxt_r.rdata = {16'h0000, r_ff.base};
                `ASQ_OFF_STAT: nxt_r.rdata = {7'h00, r_ff.conv, 1'b0, r_ff.idx,
                                              5'h00, r_ff.ioff};
                `ASQ_OFF_RES: nxt_r.rdata = {16'h0000, r_ff.result};
                default: nxt_r.rdata = 32'h0000_0000;
            endcase
        end
        if (i_avs_write & ~r_ff.waitreq) begin
            case (i_avs_address)
                `ASQ_OFF_CTRL: begin
                    wv = wmerge(ctrl_rd, i_avs_writedata, i_avs_byteenable);
                    nxt_r.on = wv[`ASQ_B_ON]; // [RULE_08]
                    nxt_r.idle_stop = wv[`ASQ_B_IDLE];
                    nxt_r.buf_mode = wv[`ASQ_B_BUFM];
                    nxt_r.ext_en = wv[`ASQ_B_EXT];
                    nxt_r.res12 = wv[`ASQ_B_RES];
                    nxt_r.fmt = wv[9:8];
                    nxt_r.trig_src = wv[7:4];
                    nxt_r.auto_sample_start = wv[`ASQ_B_AUTO_SAMPLE_START];
                    nxt_r.sample_flag = wv[`ASQ_B_SAMPLE_FLAG]; // [RULE_17]
                    if (!wv[`ASQ_B_DONE]) begin
                        nxt_r.done = 1'b0; // [RULE_17]
                    end
                end
                `ASQ_OFF_CFG: begin
                    wv = wmerge(cfg_rd, i_avs_writedata, i_avs_byteenable);
                    nxt_r.div = wv[7:0];
                    nxt_r.inc_rate = wv[12:8];
                    nxt_r.sub_size = wv[18:16];
                    nxt_r.sample_flag_time = wv[28:24];
                end
                `ASQ_OFF_BASE: begin
                    wv = wmerge({16'h0000, r_ff.base}, i_avs_writedata,
                                i_avs_byteenable);
                    nxt_r.base = wv[15:0];
                end
                default: begin
                    wv = 32'h0000_0000;
                end
            endcase
        end
        // Hardware events come after the software write so they win
        if (!r_ff.on) begin
            nxt_r.st = asq_pkg::ASQ_IDLE; // [RULE_08]
            nxt_r.conv = 1'b0;
            nxt_r.pre = 8'h00;
            nxt_r.tcnt = 5'h00;
        end else if (!halted) begin
            nxt_r.pre = tick ? 8'h00 : r_ff.pre + 8'h01;
            if (tick && r_ff.tcnt != 5'h1f) begin
                nxt_r.tcnt = r_ff.tcnt + 5'h01;
            end
            case (r_ff.st)
                asq_pkg::ASQ_IDLE: begin
                    if (r_ff.sample_flag) begin
                        nxt_r.st = asq_pkg::ASQ_SAMPLE; // [RULE_19]
                        nxt_r.pre = 8'h00;
                        nxt_r.tcnt = 5'h00;
                    end
                end
                asq_pkg::ASQ_SAMPLE: begin
                    // Prescaler restarts on each entry so TAD counts are exact
                    if ((r_ff.trig_src == `ASQ_TRIG_SW && !r_ff.sample_flag) ||
                        (r_ff.trig_src != `ASQ_TRIG_SW && trig)) begin
                        nxt_r.st = asq_pkg::ASQ_SYNC; // [RULE_14]
                        nxt_r.sample_flag = 1'b0; // [RULE_19]
                        nxt_r.done = 1'b0; // [RULE_20]
                        nxt_r.conv = 1'b1;
                        nxt_r.pre = 8'h00;
                        nxt_r.tcnt = 5'h00;
                    end else if (!r_ff.sample_flag) begin
                        nxt_r.st = asq_pkg::ASQ_IDLE;
                    end
                end
                asq_pkg::ASQ_SYNC: begin
                    // Fixed 2 TAD: inside the 1.5 to 2.5 TAD window
                    if (tick && r_ff.tcnt == `ASQ_SYNC_TAD - 5'h01) begin
                        nxt_r.st = asq_pkg::ASQ_CONV; // [RULE_05]
                        nxt_r.chan = i_channel;
                        nxt_r.tcnt = 5'h00;
                    end
                end
                asq_pkg::ASQ_CONV: begin
                    if (tick && r_ff.tcnt == conv_len - 5'h01) begin // [RULE_04]
                        nxt_r.st = asq_pkg::ASQ_IDLE;
                        nxt_r.conv = 1'b0;
                        nxt_r.done = 1'b1; // [RULE_20]
                        nxt_r.rvalid = 1'b1;
                        nxt_r.result = fmt_res(i_sar_data, r_ff.res12, r_ff.fmt);
                        nxt_r.ioff = per_channel_indirect_mode ? pia_now : 11'h000; // [RULE_10]
                        nxt_r.daddr = r_ff.base |
                                      {5'h00, (per_channel_indirect_mode ? pia_now : 11'h000)}; // [RULE_21]
                        if (per_channel_indirect_mode) begin
                            if (r_ff.rcnt == r_ff.inc_rate) begin // [RULE_22]
                                nxt_r.rcnt = 5'h00;
                                nxt_r.idx = r_ff.idx + 7'h01;
                            end else begin
                                nxt_r.rcnt = r_ff.rcnt + 5'h01;
                            end
                        end
                        if (r_ff.auto_sample_start) begin
                            nxt_r.sample_flag = 1'b1; // [RULE_16]
                        end
                    end
                end
                default: begin
                    nxt_r.st = asq_pkg::ASQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_ff <= '0;
            r_ff.waitreq <= 1'b1;
            r_ff.st <= asq_pkg::ASQ_IDLE;
            // Divider is the low byte of the config word
            r_ff.div <= 8'(`ASQ_RST_CFG);
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_avs_readdata = r_ff.rdata;
    assign o_avs_waitrequest = r_ff.waitreq;
    assign o_sampling = r_ff.sample_flag;
    assign o_converting = r_ff.conv;
    assign o_done = r_ff.done;
    assign o_result = r_ff.result;
    assign o_result_valid = r_ff.rvalid;
    assign o_indirect_offset = r_ff.ioff;
    assign o_dma_address = r_ff.daddr;

    // Helper: TAD ticks spent in sync plus conversion
    // Halted cycles add nothing, so frozen time is not counted
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hlp_ticks_ff <= 5'h00;
        end else if (r_ff.on && (r_ff.st == asq_pkg::ASQ_SYNC ||
                                 r_ff.st == asq_pkg::ASQ_CONV)) begin
            hlp_ticks_ff <= hlp_ticks_ff + {4'h0, tick & ~halted};
        end else begin
            hlp_ticks_ff <= 5'h00;
        end
    end

    default clocking asq_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_OFFSET_SIZE0: assert property ( // [RULE_01]
        $rose(o_result_valid) && $past(per_channel_indirect_mode) && r_ff.sub_size == 3'h0
        |-> o_indirect_offset == {5'h00, r_ff.chan, 1'b0})
        else $error("indirect offset wrong for one-word buffers");
    AST_OFFSET_SIZE7: assert property ( // [RULE_02]
        o_result_valid && $past(per_channel_indirect_mode) && r_ff.sub_size == 3'h7
        |-> o_indirect_offset[10:8] == r_ff.chan[2:0] && !o_indirect_offset[0])
        else $error("channel field wrong for 128-word buffers");
    AST_SYNC_LEN: assert property ( // [RULE_05]
        r_ff.st == asq_pkg::ASQ_CONV && $past(r_ff.st) == asq_pkg::ASQ_SYNC
        |-> hlp_ticks_ff == 5'h02)
        else $error("sync delay not two TAD");
    AST_CONV_LEN: assert property ( // [RULE_04]
        $rose(o_result_valid) |-> hlp_ticks_ff == $past(conv_len) + 5'h02)
        else $error("conversion length wrong");
    AST_OFF_IDLE: assert property ( // [RULE_08]
        !r_ff.on |=> r_ff.st == asq_pkg::ASQ_IDLE && !o_converting)
        else $error("converter active while off");
    AST_IDLE_HALT: assert property ( // [RULE_09]
        r_ff.on && halted && r_ff.st != asq_pkg::ASQ_IDLE |=> $stable(r_ff.st))
        else $error("converter moved while halted in idle");
    AST_DONE_PULSE: assert property ( // [RULE_20]
        $rose(o_result_valid) |-> o_done ##1 !o_result_valid)
        else $error("done not set at completion");
    AST_DONE_LOW_BUSY: assert property ( // [RULE_20]
        o_converting |-> !o_done)
        else $error("done high during conversion");
    AST_RESERVED_TRIG: assert property ( // [RULE_23]
        r_ff.st == asq_pkg::ASQ_SAMPLE && !trig && r_ff.trig_src != `ASQ_TRIG_SW
        |=> r_ff.st != asq_pkg::ASQ_SYNC)
        else $error("conversion started without a trigger");
    AST_AUTO_START: assert property ( // [RULE_16]
        $rose(o_result_valid) && $past(r_ff.auto_sample_start) |-> o_sampling)
        else $error("auto-start did not set sample bit");
    AST_DMA_OR: assert property ( // [RULE_21]
        $rose(o_result_valid) |-> o_dma_address == ($past(r_ff.base) |
                                                   {5'h00, o_indirect_offset}))
        else $error("destination address not base OR offset");
    AST_UNUSED_BITS: assert property ( // [RULE_18]
        !o_avs_waitrequest && $past(i_avs_read) && $past(i_avs_address) == `ASQ_OFF_CTRL
        |-> o_avs_readdata[14] == 1'b0 && o_avs_readdata[3] == 1'b0)
        else $error("unimplemented control bits not zero");
    AST_BUS_ONE_CYCLE: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest
        ##1 o_avs_waitrequest)
        else $error("bus answer not one cycle");
    AST_PIA_ZERO: assert property ( // [RULE_10]
        $rose(o_result_valid) && !$past(per_channel_indirect_mode) |-> o_indirect_offset == 11'h000)
        else $error("offset not zero outside indirect mode");
    AST_T1_SLEEP: assert property ( // [RULE_15]
        r_ff.st == asq_pkg::ASQ_SAMPLE && r_ff.trig_src == `ASQ_TRIG_T1NS && i_sleep_mode
        |=> r_ff.st != asq_pkg::ASQ_SYNC)
        else $error("timer 1 triggered during sleep");
    // Triggers must start sync on the very next edge
    AST_MANUAL_END: assert property ( // [RULE_19]
        r_ff.on && !halted && r_ff.st == asq_pkg::ASQ_SAMPLE &&
        r_ff.trig_src == `ASQ_TRIG_SW && !o_sampling |=> o_converting)
        else $error("clearing sample bit did not start conversion");
    AST_AUTO_TRIG: assert property ( // [RULE_14]
        r_ff.on && !halted && r_ff.st == asq_pkg::ASQ_SAMPLE &&
        r_ff.trig_src == `ASQ_TRIG_AUTO && r_ff.tcnt == r_ff.sample_flag_time
        |=> r_ff.st == asq_pkg::ASQ_SYNC)
        else $error("auto-convert count did not start conversion");

    COV_CONVERSION: cover property (
        r_ff.st == asq_pkg::ASQ_SAMPLE ##1 r_ff.st == asq_pkg::ASQ_SYNC);
    COV_PIA_128: cover property (o_result_valid && per_channel_indirect_mode && r_ff.sub_size == 3'h7);
    COV_AUTO_LOOP: cover property (
        r_ff.auto_sample_start && r_ff.trig_src == `ASQ_TRIG_AUTO && o_result_valid);
    COV_IDLE_HALT: cover property (halted && o_converting);
    COV_T1_SLEEP: cover property (i_sleep_mode && r_ff.trig_src == `ASQ_TRIG_T1 && o_result_valid);

endmodule : asq_ctrl

/* rtl/asq_params.svh */
// Purpose: Offsets, field positions, reset values and TAD counts.
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register.
// Notes: Only definitions live here.
// Notes on behaviour
// RULE_01 - Indirect offset is zero, index, channel, zero-fill
// RULE_02 - Size code gives 1 to 128 words
// RULE_03 - Software keeps offset bits of base zero
// RULE_04 - Conversion takes 12 or 14 TAD
// RULE_05 - Sync delay within 1.5 to 2.5 TAD
// RULE_06 - TAD is divider multiple of system clock
// RULE_07 - RC clock users should pick two cycles
// RULE_08 - Bit 15 turns converter on
// RULE_09 - Bit 13 halts converter in Idle
// RULE_10 - Bit 11 enables, bit 12 picks buffer mode
// RULE_11 - Bit 12 matters only with bit 11
// RULE_12 - Bit 10 selects 12-bit conversions
// RULE_13 - Format field picks justification and sign
// RULE_14 - Trigger field ends sampling, starts conversion
// RULE_15 - Timer 1 codes differ on Sleep
// RULE_16 - Auto-start sets sample bit after conversion
// RULE_17 - Software writes sample, only clears done
// RULE_18 - Bits 14 and 3 read zero
// RULE_19 - Sample bit reads one while sampling
// RULE_20 - Done sets at completion, zero before
// RULE_21 - Offset ORed with destination base
// RULE_22 - Index advances per increment rate count
// RULE_23 - Reserved trigger codes never trigger
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH
`define ASQ_OFF_CTRL 5'h00
`define ASQ_OFF_CFG 5'h04
`define ASQ_OFF_BASE 5'h08
`define ASQ_OFF_STAT 5'h0c
`define ASQ_OFF_RES 5'h10
`define ASQ_RST_CTRL 16'h0000
`define ASQ_RST_CFG 32'h0000_0000
`define ASQ_B_ON 15
`define ASQ_B_IDLE 13
`define ASQ_B_BUFM 12
`define ASQ_B_EXT 11
`define ASQ_B_RES 10
`define ASQ_B_AUTO_SAMPLE_START 2
`define ASQ_B_SAMPLE_FLAG 1
`define ASQ_B_DONE 0
`define ASQ_TRIG_SW 4'h0
`define ASQ_TRIG_INT 4'h1
`define ASQ_TRIG_TMR3 4'h2
`define ASQ_TRIG_CTU 4'h4
`define ASQ_TRIG_T1NS 4'h5
`define ASQ_TRIG_T1 4'h6
`define ASQ_TRIG_AUTO 4'h7
`define ASQ_CONV_TAD_10 5'h0c
`define ASQ_CONV_TAD_12 5'h0e
`define ASQ_SYNC_TAD 5'h02
`endif

/* rtl/asq_pkg.sv */
// Purpose: Types of the converter sequencer.
// Assumes: Used with scoped names only.
// Notes: One struct holds all state of the design except the hlp_ticks_ff helper.
package asq_pkg;
    typedef enum logic [3:0] {
        ASQ_IDLE = 4'h1,
        ASQ_SAMPLE = 4'h2,
        ASQ_SYNC = 4'h4,
        ASQ_CONV = 4'h8
    } asq_state_t;

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic on;
        logic idle_stop;
        logic buf_mode;
        logic ext_en;
        logic res12;
        logic [1:0] fmt;
        logic [3:0] trig_src;
        logic auto_sample_start;
        logic sample_flag;
        logic done;
        logic [7:0] div;
        logic [4:0] inc_rate;
        logic [2:0] sub_size;
        logic [4:0] sample_flag_time;
        logic [15:0] base;
        asq_state_t st;
        logic [7:0] pre;
        logic [4:0] tcnt;
        logic [4:0] chan;
        logic [6:0] idx;
        logic [4:0] rcnt;
        logic [10:0] ioff;
        logic [15:0] daddr;
        logic [15:0] result;
        logic rvalid;
        logic conv;
        logic int_s1;
        logic int_s2;
        logic int_d;
    } asq_regs_t;
endpackage : asq_pkg

/* verif/asq_trig_model.sv */
// Purpose: Far-side trigger sources of the sequencer.
// Assumes: Bench asks for triggers by a one-cycle fire pulse.
// Notes: Pin is asynchronous at the device, so it is held longer.
`timescale 1ns/100ps
module asq_trig_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_fire,
    output logic o_ext_int_pin,
    output logic o_timer3_trig,
    output logic o_timer1_trig,
    output logic o_ctu_trig
);
    logic [2:0] pin_cnt_ff;

    assign o_ext_int_pin = (pin_cnt_ff != 3'h0);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_cnt_ff <= 3'h0;
            o_timer3_trig <= 1'b0;
            o_timer1_trig <= 1'b0;
            o_ctu_trig <= 1'b0;
        end else begin
            // Four cycles so a two-stage synchroniser cannot miss it
            pin_cnt_ff <= i_fire[0] ? 3'h4 : pin_cnt_ff - {2'h0, o_ext_int_pin};
            o_timer3_trig <= i_fire[1];
            o_timer1_trig <= i_fire[2];
            o_ctu_trig <= i_fire[3];
        end
    end
endmodule : asq_trig_model

/* verif/test_adc_sequencer_dma_addressing.sv */
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: TAD is two clocks here (divider 1).
// Notes: Short sample times keep the run brief.
`timescale 1ns/100ps
module test_adc_sequencer_dma_addressing;
    logic clk, rst_n, rd, wr, idle, sleep, wq, smp, cnv, done, rv;
    logic ext, t3, t1, ctu;
    logic [4:0] adr, chan;
    logic [31:0] wd, rdata;
    logic [3:0] be, fire;
    logic [11:0] sar;
    logic [15:0] res, daddr;
    logic [10:0] ioff;
    int miscompares = 0;
    int comparisons = 0;

    asq_ctrl uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_idle_mode(idle),
        .i_sleep_mode(sleep), .i_ext_int_pin(ext), .i_timer3_trig(t3), .i_timer1_trig(t1),
        .i_charge_time_unit_trig(ctu), .i_channel(chan), .i_sar_data(sar), .o_sampling(smp),
        .o_converting(cnv), .o_done(done), .o_result(res), .o_result_valid(rv),
        .o_indirect_offset(ioff), .o_dma_address(daddr));
    asq_trig_model far (.i_sys_clk(clk), .i_rst_n(rst_n), .i_fire(fire),
        .o_ext_int_pin(ext), .o_timer3_trig(t3), .o_timer1_trig(t1), .o_ctu_trig(ctu));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            miscompares++;
        end
    endtask : chk

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wq !== 1'b0) begin
            miscompares++;
            results();
        end
        @(posedge clk);
    endtask : bus

    task automatic wrr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wrr

    task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rdc

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    // Cycles until the completion pulse, or -1 if none within the bound
    task automatic waitv(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rv !== 1'b1 && n < 90);
        if (rv !== 1'b1) n = -1;
        @(posedge clk);
    endtask : waitv

    task automatic conv(input logic [15:0] ctl, input logic [31:0] cfg, output int n);
        wrr(5'h04, cfg);
        wrr(5'h00, {16'h0000, ctl});
        wrr(5'h00, {16'h0000, ctl | 16'h0002});
        if (ctl[7:4] == 4'h0) begin
            wrr(5'h00, {16'h0000, ctl});
        end else begin
            fire <= 4'hf;
            @(posedge clk);
            fire <= 4'h0;
        end
        waitv(n);
    endtask : conv

    function automatic logic [15:0] fmt_exp(input logic m, input logic [1:0] f,
            input logic [11:0] r);
        logic [15:0] u;
        logic [15:0] s;
        u = m ? {4'h0, r} : {6'h00, r[9:0]};
        s = u - (m ? 16'h0800 : 16'h0200);
        case (f)
            2'b00: return u;
            2'b01: return s;
            2'b10: return m ? u << 4 : u << 6;
            default: return m ? s << 4 : s << 6;
        endcase
    endfunction : fmt_exp

    task automatic t_regs;
        rdc("ctrl_reset", 5'h00, 32'h0);
        rdc("unmapped", 5'h14, 32'h0);
        wrr(5'h00, 32'h0000_4008);
        rdc("ctrl_unimpl", 5'h00, 32'h0);
        wrr(5'h00, 32'h0000_fff8);
        rdc("ctrl_rw", 5'h00, 32'h0000_bff0);
        wrr(5'h00, 32'h0);
    endtask : t_regs

    task automatic t_format;
        int n;
        int t;
        logic [15:0] ctl;
        for (int i = 0; i < 8; i++) begin
            ctl = 16'h8000 | (i[2] ? 16'h0400 : 16'h0000) | {6'h00, i[1:0], 8'h00};
            // Sync starts at the return edge; valid is seen one negedge after its edge
            t = i[2] ? 33 : 29;
            conv(ctl, 32'h0000_0001, n);
            chk("result", {16'h0000, fmt_exp(i[2], i[1:0], sar)}, {16'h0000, res});
            chk("conv_time", 32'(t), 32'(n));
            rdc("done_read", 5'h00, {16'h0000, ctl | 16'h0001});
        end
    endtask : t_format

    task automatic t_idle;
        int n;
        wrr(5'h00, 32'h0000_a002);
        wrr(5'h00, 32'h0000_a000);
        idle <= 1'b1;
        waitv(n);
        chk("idle_frozen", 32'h0, 32'(n > 0));
        chk("idle_busy", 32'h1, 32'(cnv));
        idle <= 1'b0;
        waitv(n);
        chk("idle_resume", 32'h1, 32'(n > 0));
        idle <= 1'b1;
        conv(16'h8000, 32'h0000_0001, n);
        chk("idle_run", 32'h1, 32'(n > 0));
        idle <= 1'b0;
    endtask : t_idle

    task automatic t_trig;
        int n;
        logic [3:0] codes [9] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h3, 4'h8, 4'hf};
        for (int i = 0; i < 9; i++) begin
            conv(16'h8000 | {8'h00, codes[i], 4'h0}, 32'h0200_0001, n);
            chk("trig_fired", 32'(i < 6), 32'(n > 0));
        end
        sleep <= 1'b1;
        conv(16'h8050, 32'h0200_0001, n);
        chk("t1_sleep_off", 32'h0, 32'(n > 0));
        conv(16'h8060, 32'h0200_0001, n);
        chk("t1_sleep_on", 32'h1, 32'(n > 0));
        sleep <= 1'b0;
    endtask : t_trig

    task automatic t_auto;
        int n;
        conv(16'h8014, 32'h0000_0001, n);
        @(negedge clk);
        chk("auto_resample", 32'h1, 32'(smp));
        chk("done_set", 32'h1, 32'(done));
        @(posedge clk);
        wrr(5'h00, 32'h0000_8015);
        chk("done_w1", 32'h1, 32'(done));
        wrr(5'h00, 32'h0000_8014);
        chk("done_w0", 32'h0, 32'(done));
    endtask : t_auto

    task automatic t_pia;
        int n;
        logic [10:0] eo [3] = '{11'h028, 11'h028, 11'h02a};
        do_reset();
        chan <= 5'h05;
        wrr(5'h08, 32'h0000_1000);
        for (int i = 0; i < 3; i++) begin
            conv(16'h8800, 32'h0002_0101, n);
            chk("offset", {21'h0, eo[i]}, {21'h0, ioff});
            chk("dma_addr", {16'h0000, 16'h1000 | {5'h00, eo[i]}}, {16'h0000, daddr});
        end
        conv(16'h9800, 32'h0002_0101, n);
        chk("ext_buf_off", 32'h0, {21'h0, ioff});
        conv(16'h8000, 32'h0002_0101, n);
        chk("no_ext_ran", 32'h1, 32'(n > 0));
        chk("no_ext_off", 32'h0, {21'h0, ioff});
        do_reset();
        chan <= 5'h03;
        conv(16'h8800, 32'h0007_0001, n);
        chk("offset_128", 32'h0000_0300, {21'h0, ioff});
    endtask : t_pia

    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 5'h00;
        wd = 32'h0;
        be = 4'hf;
        idle = 1'b0;
        sleep = 1'b0;
        fire = 4'h0;
        chan = 5'h02;
        sar = 12'h3a5;
        do_reset();
        t_regs();
        t_format();
        t_idle();
        t_trig();
        t_auto();
        t_pia();
        results();
    end
endmodule : test_adc_sequencer_dma_addressing
